/* verilog/difm_map.vh */
// register map, field positions, reset values and timing counts of the input mapper
`ifndef DIFM_MAP_VH
`define DIFM_MAP_VH
`define DIFM_ADDR_W 6
`define DIFM_OFF_SEL_LO 6'h00
`define DIFM_OFF_SEL_HI 6'h04
`define DIFM_OFF_CTRL 6'h08
`define DIFM_OFF_STAT 6'h0C
`define DIFM_OFF_PIN 6'h10
`define DIFM_OFF_GPIN 6'h14
`define DIFM_OFF_CMD 6'h18
`define DIFM_SEL_LO_RST 32'h10001001
`define DIFM_SEL_HI_RST 32'h00111111
`define DIFM_SEL_MAX 4'h5
`define DIFM_CTRL_AUTO 0
`define DIFM_CTRL_AUTOOP 1
`define DIFM_CTRL_CUT_CAUSE 2
`define DIFM_CTRL_ESTOP_CONT 3
`define DIFM_CTRL_PWR_LOCAL 4
`define DIFM_RESP_OKAY 2'b00
`define DIFM_RESP_SLVERR 2'b10
`define DIFM_CLK_KHZ 50000
`define DIFM_SRST_MS 1000
`define DIFM_SRST_CYC (`DIFM_SRST_MS * `DIFM_CLK_KHZ)
`endif

/* verilog/difm_sync.v */
// two-stage synchroniser with rising and falling edge pulses for a bus of inputs
`timescale 1ns/100ps
`default_nettype none
module difm_sync #(
   parameter W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] din,
   output wire [W-1:0] lvl,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // edges look only at the second and third stages
   assign lvl = s2_r;
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

/* verilog/difm_top.v */
// dedicated input function mapper with AXI4-Lite register access
// Function
// - selection zero is general input; values above five are refused.
// - input 0 at one starts program on rising edge, BCD number.
// - input 0 at two starts program on rising edge, binary number.
// - input 1 at one: software reset after one second high.
// - input 2 servo: rising edge servo on, falling edge servo off.
// - input 3 at one: auto-start after reset in AUTO mode; here after software reset only, as reset clears AUTO.
// - input 3 at two: rise starts auto program, fall aborts all.
// - input 4 at one: low level asserts soft interlock on all axes.
// - interlock holds motion in automatic run, terminates outside AUTO.
// - input 5 at one: rising edge resets operation pause.
// - input 6 dedicated: low pauses in automatic run; reset clears it (here only at selection one).
// - inputs 7..13 form number, 7 LSB; 13 may be error reset.
// - input 14 at one: rising edge resets cutoff once cause gone.
// - input 14 at zero: cutoff releases itself once cause gone.
// - no cutoff reset control for axes with external power units.
// - input 15: one homes all axes, two homes incremental axes.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "difm_map.vh"
module difm_top #(
   parameter SRST_CYC = `DIFM_SRST_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] in_pin,
   input wire [`DIFM_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`DIFM_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg prog_start_r,
   output reg [6:0] prog_num_r,
   output reg soft_reset_r,
   output reg servo_on_r,
   output reg servo_off_r,
   output reg auto_start_r,
   output reg abort_all_r,
   output reg interlock_r,
   output reg motion_hold_r,
   output reg motion_stop_r,
   output reg pause_r,
   output reg err_reset_r,
   output reg cutoff_r,
   output reg home_all_r,
   output reg home_inc_r
);
   wire [15:0] lvl;
   wire [15:0] rise;
   wire [15:0] fall;
   reg [63:0] sel_r;
   reg [4:0] ctrl_r;
   reg [15:0] cmd_r;
   reg [31:0] wcnt_r;
   reg boot_r;
   reg [`DIFM_ADDR_W-1:0] awaddr_r;
   reg [31:0] wdata_r;
   reg aw_got_r;
   reg w_got_r;
   reg [15:0] gp_mask;
   reg [6:0] num_nxt;
   reg [31:0] rd_nxt;
   reg rd_ok;
   integer i;

   difm_sync #(.W(16)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(in_pin),
      .lvl(lvl),
      .rise(rise),
      .fall(fall)
   );

   // selection field of input n
   function [3:0] fsel;
      input [63:0] s;
      input [3:0] n;
      begin
         fsel = s[n*4 +: 4];
      end
   endfunction

   // seven-bit code read as two BCD digits, low digit first
   function [6:0] bcd2bin;
      input [6:0] b;
      reg [6:0] tens;
      begin
         tens = {4'h0, b[6:4]};
         bcd2bin = (tens << 3) + (tens << 1) + {3'h0, b[3:0]};
      end
   endfunction

   // a field write above five keeps that field's old value
   function [31:0] sel_wr;
      input [31:0] old;
      input [31:0] nw;
      integer k;
      begin
         sel_wr = old;
         for (k = 0; k < 8; k = k + 1)
            if (nw[k*4 +: 4] <= `DIFM_SEL_MAX)
               sel_wr[k*4 +: 4] = nw[k*4 +: 4];
      end
   endfunction

   wire pe_start = (fsel(sel_r, 4'd0) == 4'h1) || (fsel(sel_r, 4'd0) == 4'h2);
   wire pe_srst = fsel(sel_r, 4'd1) == 4'h1;
   wire pe_servo = fsel(sel_r, 4'd2) == 4'h1;
   wire pe_auto1 = fsel(sel_r, 4'd3) == 4'h1;
   wire pe_auto2 = fsel(sel_r, 4'd3) == 4'h2;
   wire pe_ilk = fsel(sel_r, 4'd4) == 4'h1;
   wire pe_prst = fsel(sel_r, 4'd5) == 4'h1;
   wire pe_pause = fsel(sel_r, 4'd6) == 4'h1;
   wire pe_err = fsel(sel_r, 4'd13) == 4'h2;
   wire pe_cut = fsel(sel_r, 4'd14) == 4'h1;
   wire pe_home1 = fsel(sel_r, 4'd15) == 4'h1;
   wire pe_home2 = fsel(sel_r, 4'd15) == 4'h2;
   wire in_auto = ctrl_r[`DIFM_CTRL_AUTO];
   wire in_autoop = ctrl_r[`DIFM_CTRL_AUTOOP];
   wire cut_cause = ctrl_r[`DIFM_CTRL_CUT_CAUSE];
   wire pwr_local = ctrl_r[`DIFM_CTRL_PWR_LOCAL];
   wire srst_fire = pe_srst && lvl[1] && (wcnt_r == SRST_CYC - 1);

   // program-number field; undocumented values fall back to general input
   always @*
   begin
      gp_mask = 16'h0000;
      for (i = 0; i < 16; i = i + 1)
         gp_mask[i] = 1'b1;
      gp_mask[0] = !pe_start;
      gp_mask[1] = !pe_srst;
      gp_mask[2] = !pe_servo;
      gp_mask[3] = !pe_auto2;
      gp_mask[4] = !pe_ilk;
      gp_mask[5] = !pe_prst;
      gp_mask[6] = !pe_pause;
      for (i = 7; i < 14; i = i + 1)
         gp_mask[i] = fsel(sel_r, i[3:0]) != 4'h1;
      if (pe_err)
         gp_mask[13] = 1'b0;
      gp_mask[14] = !pe_cut;
      gp_mask[15] = !(pe_home1 || pe_home2);
      num_nxt = lvl[13:7] & ~gp_mask[13:7];
      if (fsel(sel_r, 4'd0) == 4'h1)
         num_nxt = bcd2bin(num_nxt);
   end

   // function decode and command pulses
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prog_start_r <= 1'b0;
         prog_num_r <= 7'h00;
         soft_reset_r <= 1'b0;
         servo_on_r <= 1'b0;
         servo_off_r <= 1'b0;
         auto_start_r <= 1'b0;
         abort_all_r <= 1'b0;
         interlock_r <= 1'b0;
         motion_hold_r <= 1'b0;
         motion_stop_r <= 1'b0;
         pause_r <= 1'b0;
         err_reset_r <= 1'b0;
         cutoff_r <= 1'b0;
         home_all_r <= 1'b0;
         home_inc_r <= 1'b0;
         wcnt_r <= 32'h00000000;
         boot_r <= 1'b1;
         cmd_r <= 16'h0000;
      end
      else
      begin
         prog_start_r <= pe_start && rise[0];
         if (pe_start && rise[0])
            prog_num_r <= num_nxt;
         // one second continuous high, fired once per press
         if (pe_srst && lvl[1])
         begin
            if (wcnt_r != SRST_CYC)
               wcnt_r <= wcnt_r + 32'h00000001;
         end
         else
            wcnt_r <= 32'h00000000;
         soft_reset_r <= srst_fire;
         servo_on_r <= pe_servo && rise[2];
         servo_off_r <= pe_servo && fall[2];
         boot_r <= srst_fire;
         auto_start_r <= (pe_auto2 && rise[3]) || (pe_auto1 && in_auto && boot_r);
         abort_all_r <= pe_auto2 && fall[3];
         interlock_r <= pe_ilk && !lvl[4];
         motion_hold_r <= pe_ilk && !lvl[4] && in_autoop;
         motion_stop_r <= pe_ilk && !lvl[4] && !in_auto;
         // pause reset wins over a held pause level
         if (pe_prst && rise[5])
            pause_r <= 1'b0;
         else if (pe_pause && !lvl[6] && in_autoop)
            pause_r <= 1'b1;
         err_reset_r <= pe_err && rise[13];
         // external power units are outside cutoff control
         if (!pwr_local)
            cutoff_r <= 1'b0;
         else if (cut_cause)
            cutoff_r <= 1'b1;
         else if (!pe_cut || rise[14])
            cutoff_r <= 1'b0;
         home_all_r <= pe_home1 && rise[15];
         home_inc_r <= pe_home2 && rise[15];
         // sticky log: bits stay until software writes ones to clear them,
         // and a pulse in the clearing cycle still lands, so no event is lost
         cmd_r <= {home_inc_r, home_all_r, err_reset_r, abort_all_r, auto_start_r,
            servo_off_r, servo_on_r, soft_reset_r, prog_start_r, 7'h00} | cmd_r;
         if (aw_got_r && w_got_r && !s_axi_bvalid && awaddr_r == `DIFM_OFF_CMD)
            cmd_r <= {home_inc_r, home_all_r, err_reset_r, abort_all_r, auto_start_r,
               servo_off_r, servo_on_r, soft_reset_r, prog_start_r, 7'h00}
               | (cmd_r & ~wdata_r[15:0]);
      end
   end

   // AXI4-Lite write: address and data in either order, response after both
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DIFM_RESP_OKAY;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= {`DIFM_ADDR_W{1'b0}};
         wdata_r <= 32'h00000000;
         sel_r <= {`DIFM_SEL_HI_RST, `DIFM_SEL_LO_RST};
         ctrl_r <= 5'h10;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_r <= s_axi_awaddr;
            aw_got_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_r <= s_axi_wdata;
            w_got_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_got_r && w_got_r && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `DIFM_RESP_OKAY;
            // byte strobes ignored: whole-word writes only
            if (awaddr_r == `DIFM_OFF_SEL_LO)
               sel_r[31:0] <= sel_wr(sel_r[31:0], wdata_r);
            else if (awaddr_r == `DIFM_OFF_SEL_HI)
               sel_r[63:32] <= sel_wr(sel_r[63:32], wdata_r);
            else if (awaddr_r == `DIFM_OFF_CTRL)
               ctrl_r <= wdata_r[4:0];
            else if (awaddr_r != `DIFM_OFF_CMD)
               s_axi_bresp <= `DIFM_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @*
   begin
      rd_ok = 1'b1;
      rd_nxt = 32'h00000000;
      if (s_axi_araddr == `DIFM_OFF_SEL_LO)
         rd_nxt = sel_r[31:0];
      else if (s_axi_araddr == `DIFM_OFF_SEL_HI)
         rd_nxt = sel_r[63:32];
      else if (s_axi_araddr == `DIFM_OFF_CTRL)
         rd_nxt = {27'h0000000, ctrl_r};
      else if (s_axi_araddr == `DIFM_OFF_STAT)
         rd_nxt = {16'h0000, cutoff_r, pause_r, motion_stop_r, motion_hold_r,
            interlock_r, servo_on_r, 3'h0, prog_num_r};
      else if (s_axi_araddr == `DIFM_OFF_PIN)
         rd_nxt = {16'h0000, lvl};
      else if (s_axi_araddr == `DIFM_OFF_GPIN)
         rd_nxt = {16'h0000, lvl & gp_mask};
      else if (s_axi_araddr == `DIFM_OFF_CMD)
         rd_nxt = {16'h0000, cmd_r};
      else
         rd_ok = 1'b0;
   end

   // AXI4-Lite read: one cycle to rvalid after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DIFM_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_nxt;
         s_axi_rresp <= rd_ok ? `DIFM_RESP_OKAY : `DIFM_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* sim/difm_chk_assertions.sv */
// concurrent checks on the input mapper command outputs
`timescale 1ns/100ps
`default_nettype none
module difm_chk #(
   parameter SRST_CYC = 20
) (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] in_pin,
   input wire prog_start_r,
   input wire soft_reset_r,
   input wire servo_on_r,
   input wire servo_off_r,
   input wire abort_all_r,
   input wire interlock_r,
   input wire home_all_r,
   input wire home_inc_r
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // run length of the reset request pin
   integer hi_r;
   always @(posedge aclk)
      hi_r <= (in_pin[1] && aresetn) ? hi_r + 1 : 0;
   property p_start;
      prog_start_r |-> $past(in_pin[0], 2) ##1 !prog_start_r;
   endproperty
   a_start: assert property (p_start) else $error("start without pin");
   property p_srst;
      soft_reset_r |-> hi_r >= SRST_CYC;
   endproperty
   a_srst: assert property (p_srst) else $error("reset too early");
   property p_son;
      servo_on_r |-> $past(in_pin[2], 2) && !servo_off_r;
   endproperty
   a_son: assert property (p_son) else $error("servo on wrong");
   property p_soff;
      servo_off_r |-> !$past(in_pin[2], 2);
   endproperty
   a_soff: assert property (p_soff) else $error("servo off wrong");
   property p_abort;
      abort_all_r |-> !$past(in_pin[3], 2);
   endproperty
   a_abort: assert property (p_abort) else $error("abort while high");
   property p_ilk;
      $rose(interlock_r) |-> !$past(in_pin[4], 2);
   endproperty
   a_ilk: assert property (p_ilk) else $error("interlock while high");
   property p_hall;
      home_all_r |-> $past(in_pin[15], 2) && !home_inc_r;
   endproperty
   a_hall: assert property (p_hall) else $error("home all wrong");
   property p_hinc;
      home_inc_r |-> $past(in_pin[15], 2);
   endproperty
   a_hinc: assert property (p_hinc) else $error("home inc wrong");
   c_start: cover property (prog_start_r);
   c_srst: cover property (soft_reset_r);
   c_hinc: cover property (home_inc_r);
endmodule
bind difm_top difm_chk #(.SRST_CYC(SRST_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
   .in_pin(in_pin), .prog_start_r(prog_start_r), .soft_reset_r(soft_reset_r),
   .servo_on_r(servo_on_r), .servo_off_r(servo_off_r), .abort_all_r(abort_all_r),
   .interlock_r(interlock_r), .home_all_r(home_all_r), .home_inc_r(home_inc_r));
`default_nettype wire

/* sim/difm_host.sv */
// host switches driving the input ports
`timescale 1ns/100ps
`default_nettype none
module difm_host #(
   parameter GAP = 20
) (
   input wire aclk,
   input wire [15:0] want,
   output logic [15:0] in_pin = 16'h0000
);
   // start and servo pins move only after a quiet spell
   integer cnt_r = 0;
   always @(posedge aclk)
   begin
      cnt_r <= (cnt_r >= GAP && (want[0] != in_pin[0] || want[2] != in_pin[2])) ? 0 : cnt_r + 1;
      in_pin[15:3] <= want[15:3];
      in_pin[1] <= want[1];
      if (cnt_r >= GAP)
      begin
         in_pin[0] <= want[0];
         in_pin[2] <= want[2];
      end
   end
endmodule
`default_nettype wire

/* sim/difm_tb_top.sv */
// self-checking bench for the input function mapper
`timescale 1ns/100ps
`default_nettype none
`include "difm_map.vh"
module difm_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] want = 16'h0000;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] in_pin;
   wire [6:0] pnum;
   wire [13:0] o;
   integer n_mismatch = 0;
   integer num_checks = 0;
   always #10 aclk = ~aclk;
   difm_host #(.GAP(20)) i_host (.aclk(aclk), .want(want), .in_pin(in_pin));
   difm_top #(.SRST_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn), .in_pin(in_pin),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .prog_start_r(o[0]), .prog_num_r(pnum), .soft_reset_r(o[1]), .servo_on_r(o[2]),
      .servo_off_r(o[3]), .auto_start_r(o[4]), .abort_all_r(o[5]), .interlock_r(o[6]),
      .motion_hold_r(o[7]), .motion_stop_r(o[8]), .pause_r(o[9]), .err_reset_r(o[10]),
      .cutoff_r(o[11]), .home_all_r(o[12]), .home_inc_r(o[13]));
   task report_and_stop;
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task tmo;
      n_mismatch++;
      report_and_stop;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      integer i;
      @(posedge aclk);
      i = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         i++;
      end
      while (bvalid !== 1'b1 && i < 50);
      bready <= 1'b0;
      if (bvalid !== 1'b1) tmo;
      chk(bresp, er);
   endtask
   task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
      integer i;
      @(posedge aclk);
      i = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         i++;
      end
      while (rvalid !== 1'b1 && i < 50);
      rready <= 1'b0;
      if (rvalid !== 1'b1) tmo;
      chk(rresp, er);
      if (er == 2'h0) chk(rdata, ed);
   endtask
   task pn(input integer b, input logic v);
      integer i;
      @(posedge aclk);
      want[b] <= v;
      // the host holds start and servo pins back for its quiet spell
      for (i = 0; i < 100 && in_pin[b] !== v; i++)
         @(posedge aclk);
      if (in_pin[b] !== v) tmo;
   endtask
   // sampled mid-cycle so one-cycle pulses are seen settled
   task wt(input integer k, input logic v);
      integer i;
      @(negedge aclk);
      for (i = 0; i < 200 && o[k] !== v; i++)
         @(negedge aclk);
      if (i >= 200) tmo;
      chk(o[k], v);
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(6'h00, `DIFM_SEL_LO_RST, 2'h0);
      rd(6'h04, `DIFM_SEL_HI_RST, 2'h0);
      rd(6'h08, 32'h00000010, 2'h0);
      wr(6'h00, 32'h1006100F, 2'h0);
      rd(6'h00, `DIFM_SEL_LO_RST, 2'h0);
      wr(6'h20, 32'h00000000, `DIFM_RESP_SLVERR);
      rd(6'h3C, 32'h00000000, `DIFM_RESP_SLVERR);
      wr(6'h00, 32'h11112111, 2'h0);
      wr(6'h04, 32'h10111111, 2'h0);
      wr(6'h08, 32'h00000010, 2'h0);
      wt(6, 1'b1);
      wt(8, 1'b1);
      wr(6'h08, 32'h00000013, 2'h0);
      wt(7, 1'b1);
      wt(8, 1'b0);
      wt(9, 1'b1);
      pn(6, 1'b1);
      pn(5, 1'b1);
      wt(9, 1'b0);
      pn(4, 1'b1);
      wt(6, 1'b0);
      @(posedge aclk);
      want[13:7] <= 7'h25;
      pn(0, 1'b1);
      wt(0, 1'b1);
      chk(pnum, 7'h19);
      pn(0, 1'b0);
      wr(6'h00, 32'h11112112, 2'h0);
      pn(0, 1'b1);
      wt(0, 1'b1);
      chk(pnum, 7'h25);
      pn(0, 1'b0);
      pn(2, 1'b1);
      wt(2, 1'b1);
      pn(15, 1'b1);
      wt(12, 1'b1);
      pn(15, 1'b0);
      wr(6'h04, 32'h20111111, 2'h0);
      pn(15, 1'b1);
      wt(13, 1'b1);
      pn(15, 1'b0);
      pn(2, 1'b0);
      wt(3, 1'b1);
      pn(3, 1'b1);
      wt(4, 1'b1);
      pn(3, 1'b0);
      wt(5, 1'b1);
      wr(6'h04, 32'h20211111, 2'h0);
      pn(13, 1'b1);
      wt(10, 1'b1);
      wr(6'h00, 32'h11111112, 2'h0);
      wr(6'h08, 32'h00000019, 2'h0);
      pn(1, 1'b1);
      wt(1, 1'b1);
      @(negedge aclk);
      chk(o[4], 1'b1);
      pn(1, 1'b0);
      wr(6'h08, 32'h00000014, 2'h0);
      wt(11, 1'b1);
      wr(6'h08, 32'h00000010, 2'h0);
      wt(11, 1'b0);
      wr(6'h04, 32'h21211111, 2'h0);
      wr(6'h08, 32'h00000014, 2'h0);
      wt(11, 1'b1);
      wr(6'h08, 32'h00000010, 2'h0);
      repeat (8) @(negedge aclk);
      chk(o[11], 1'b1);
      pn(14, 1'b1);
      wt(11, 1'b0);
      wr(6'h08, 32'h00000014, 2'h0);
      wt(11, 1'b1);
      wr(6'h08, 32'h00000004, 2'h0);
      wt(11, 1'b0);
      wr(6'h04, 32'h51211111, 2'h0);
      pn(15, 1'b1);
      repeat (8)
      begin
         @(negedge aclk);
         chk(o[13:12], 2'h0);
      end
      rd(6'h10, 32'h0000F2F0, 2'h0);
      rd(6'h14, 32'h00008000, 2'h0);
      rd(6'h0C, 32'h00000025, 2'h0);
      rd(6'h18, 32'h0000FF80, 2'h0);
      wr(6'h18, 32'h0000FF80, 2'h0);
      rd(6'h18, 32'h00000000, 2'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
